// [shared/breaker_cfg.svh]
// Functional notes
// - Return switch gate turns fully on once the first port reaches idle.
// - Qualified forward over-threshold trips breaker; non-disabled ports forced to overload.
// - Sense inputs: port 0 own, ports 1-2 shared, ports 3-4 shared.
// - Internal ground path closes whenever the return switch is off.
// - Deep-sleep switch stays closed except after trip or overcurrent, recloses after delay.
// - While negative-voltage fault is handled, all ports held in overload.
// - Config: five-bit input select, two-bit sample mode; one select is temperature.
// - First result 3.6 ms after enable, then every 1.8 ms in continuous mode.
// - Result bit 12 flags a fresh conversion result.
// - Port current code valid only in power-up or power-on state.
// - Port current results refresh every 1.8 ms.
`ifndef BREAKER_CFG_SVH
`define BREAKER_CFG_SVH
`define CLK_MHZ          125
`define FIRST_US         3600
`define FIRST_CYC        (`FIRST_US * `CLK_MHZ)
`define PERIOD_US        1800
`define PERIOD_CYC       (`PERIOD_US * `CLK_MHZ)
`define QUAL_CYC         16
`define RESTART_CYC      1024
`define SEL_LSB          0
`define SEL_MSB          4
`define MODE_LSB         5
`define MODE_MSB         6
`define FRESH_BIT        12
`define SEL_TEMP         5'h1f
`define CFG_RESET        16'h0000
`endif

// [shared/breaker_pkg.sv]
`default_nettype none
package breaker_pkg;
    typedef enum logic [2:0] {
        PS_DISABLED, PS_SLEEP, PS_IDLE, PS_POWER_UP, PS_POWER_ON, PS_OVERLOAD, PS_OTHER
    } port_state_e;
    typedef enum logic [1:0] {
        MODE_OFF, MODE_SINGLE, MODE_CONT, MODE_RSVD
    } sample_mode_e;
endpackage
`default_nettype wire

// [core/fault_qualifier.sv]
`timescale 1ns/100ps
`default_nettype none
`include "breaker_cfg.svh"
module fault_qualifier #(
    parameter int QUAL = `QUAL_CYC
) (
    input  wire logic ref_clk,  // Clock
    input  wire logic rst_n,    // Sync reset
    input  wire logic clk_en,   // Clock enable
    input  wire logic cmp_in,   // Raw comparator
    output logic      qualified // Held long enough
);
    logic       s1_q;
    logic       s2_q;
    logic [15:0] cnt_q;

    // Two-stage synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end
        else if (clk_en)
        begin
            s1_q <= cmp_in;
            s2_q <= s1_q;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cnt_q <= 16'h0000;
        else if (clk_en)
        begin
            if (!s2_q)
                cnt_q <= 16'h0000;
            else if (cnt_q != 16'(QUAL))
                cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign qualified = (cnt_q == 16'(QUAL));
endmodule
`default_nettype wire

// [core/return_breaker_and_telemetry.sv]
`timescale 1ns/100ps
`default_nettype none
`include "breaker_cfg.svh"
module return_breaker_and_telemetry #(
    parameter int NPORT       = 5,
    parameter int FIRST_CYC   = `FIRST_CYC,
    parameter int PERIOD_CYC  = `PERIOD_CYC,
    parameter int RESTART_CYC = `RESTART_CYC
) (
    input  wire logic         ref_clk,            // 125 MHz clock
    input  wire logic         rst_n,              // Sync reset, active low
    input  wire logic         clk_en,             // Freezes state when low
    input  wire logic [14:0]  port_state,         // 3 bits per port, port_state_e
    input  wire logic         port0_return_sense, // Port 0 forward comparator
    input  wire logic         sense12_cmp,        // Shared ports 1/2 comparator
    input  wire logic         sense34_cmp,        // Shared ports 3/4 comparator
    input  wire logic         overcurrent,        // Overcurrent fault event
    input  wire logic         neg_fault,          // Forced negative voltage fault
    input  wire logic         cfg_wr,             // Config write strobe
    input  wire logic [15:0]  cfg_wdata,          // Config write data
    input  wire logic         res_rd,             // Result read strobe
    input  wire logic [11:0]  adc_code,           // Converter sample input
    input  wire logic [59:0]  port_adc_code,      // Per-port current samples
    output logic [15:0]       cfg_rdata,          // global_converter_config
    output logic [15:0]       res_rdata,          // global_converter_result
    output logic [79:0]       port_res_rdata,     // port_current_result x5
    output logic              return_switch_gate, // External return switch on
    output logic              ground_path_on,     // Internal return path closed
    output logic              sleep_switch_on,    // Deep-sleep return switch
    output logic [4:0]        force_overload      // Per-port overload request
);
    logic [15:0] cfg_q;
    logic [11:0] code_q;
    logic        fresh_q;
    logic        gate_q;
    logic        trip_q;
    logic        sleep_q;
    logic [15:0] rst_cnt_q;
    logic [31:0] conv_cnt_q;
    logic        conv_first_q;
    logic        conv_run_q;
    logic [31:0] port_cnt_q;
    logic [59:0] port_code_q;
    logic [2:0]  q_hit;
    logic [4:0]  any_idle;
    logic [4:0]  not_dis;
    logic [4:0]  valid_st;
    logic        trip_now;
    logic        conv_done;

    ////////////////////////////////////////////////////////////////////////
    // Per-port decode of state
    genvar g;
    generate
        for (g = 0; g < NPORT; g++)
        begin : g_port
            logic [2:0] st;
            assign st          = port_state[3*g +: 3];
            assign any_idle[g] = (st == breaker_pkg::PS_IDLE);
            assign not_dis[g]  = (st != breaker_pkg::PS_DISABLED);
            assign valid_st[g] = (st == breaker_pkg::PS_POWER_UP) ||
                                 (st == breaker_pkg::PS_POWER_ON);
            assign port_res_rdata[16*g +: 16] =
                valid_st[g] ? {4'h0, port_code_q[12*g +: 12]} : 16'h0000;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // three sense channels qualified
    fault_qualifier u_q0 (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .cmp_in    (port0_return_sense),
        .qualified (q_hit[0])
    );
    fault_qualifier u_q12 (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .cmp_in    (sense12_cmp),
        .qualified (q_hit[1])
    );
    fault_qualifier u_q34 (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .cmp_in    (sense34_cmp),
        .qualified (q_hit[2])
    );

    assign trip_now = gate_q && (|q_hit);

    // gate on at first idle; trip opens it
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            gate_q <= 1'b0;
        else if (clk_en)
        begin
            if (trip_now)
                gate_q <= 1'b0;
            else if (|any_idle && !trip_q)
                gate_q <= 1'b1;
        end
    end

    // trip latch; restart delay releases it
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            trip_q    <= 1'b0;
            sleep_q   <= 1'b1;
            rst_cnt_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            if (trip_now || overcurrent)
            begin
                trip_q    <= trip_q || trip_now; // Overcurrent keeps a pending trip
                sleep_q   <= 1'b0;
                rst_cnt_q <= 16'h0000;
            end
            else if (!sleep_q)
            begin
                if (rst_cnt_q == 16'(RESTART_CYC - 1))
                begin
                    sleep_q <= 1'b1;
                    trip_q  <= 1'b0;
                end
                else
                    rst_cnt_q <= rst_cnt_q + 16'h0001;
            end
        end
    end

    assign force_overload     = neg_fault ? 5'h1f : (trip_q ? not_dis : 5'h00);
    assign return_switch_gate = gate_q;
    assign ground_path_on     = !gate_q;
    assign sleep_switch_on    = sleep_q;

    ////////////////////////////////////////////////////////////////////////
    // config register
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cfg_q <= `CFG_RESET;
        else if (clk_en && cfg_wr)
            cfg_q <= {9'h000, cfg_wdata[`MODE_MSB:`SEL_LSB]};
    end
    assign cfg_rdata = cfg_q;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            conv_cnt_q   <= 32'h0;
            conv_first_q <= 1'b1;
            conv_run_q   <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cfg_wr)
            begin
                conv_cnt_q   <= 32'h0;
                conv_first_q <= 1'b1;
                conv_run_q   <= (cfg_wdata[`MODE_MSB:`MODE_LSB] == breaker_pkg::MODE_SINGLE) ||
                                (cfg_wdata[`MODE_MSB:`MODE_LSB] == breaker_pkg::MODE_CONT);
            end
            else if (conv_run_q)
            begin
                if (conv_done)
                begin
                    conv_cnt_q   <= 32'h0;
                    conv_first_q <= 1'b0;
                    conv_run_q   <= (cfg_q[`MODE_MSB:`MODE_LSB] == breaker_pkg::MODE_CONT);
                end
                else
                    conv_cnt_q <= conv_cnt_q + 32'h1;
            end
        end
    end
    assign conv_done = conv_run_q && (conv_cnt_q ==
        (conv_first_q ? 32'(FIRST_CYC - 1) : 32'(PERIOD_CYC - 1)));

    // result and fresh flag, set wins over read clear
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            code_q  <= 12'h000;
            fresh_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (conv_done && !cfg_wr)
            begin
                code_q  <= adc_code;
                fresh_q <= 1'b1;
            end
            else if (res_rd)
                fresh_q <= 1'b0;
        end
    end
    assign res_rdata = {3'h0, fresh_q, code_q};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            port_cnt_q  <= 32'h0;
            port_code_q <= 60'h0;
        end
        else if (clk_en)
        begin
            if (port_cnt_q == 32'(PERIOD_CYC - 1))
            begin
                port_cnt_q  <= 32'h0;
                port_code_q <= port_adc_code;
            end
            else
                port_cnt_q <= port_cnt_q + 32'h1;
        end
    end
endmodule
`default_nettype wire

// [tb/breaker_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module breaker_monitor #(
    parameter int RESTART_CYC = 8
) (
    input wire logic        ref_clk,            // Clock
    input wire logic        rst_n,              // Reset
    input wire logic        clk_en,             // Clock enable
    input wire logic        port0_return_sense, // Sense 0
    input wire logic        sense12_cmp,        // Sense 1/2
    input wire logic        sense34_cmp,        // Sense 3/4
    input wire logic        neg_fault,          // Neg fault
    input wire logic        cfg_wr,             // Write
    input wire logic [15:0] cfg_wdata,          // Wdata
    input wire logic [15:0] cfg_rdata,          // Config
    input wire logic        return_switch_gate, // Gate
    input wire logic        ground_path_on,     // Path
    input wire logic        sleep_switch_on,    // Sleep
    input wire logic [4:0]  force_overload      // Force
);
    localparam int RHI = RESTART_CYC + 3;
    logic any_cmp; // Any forward comparator
    // Merge the three sense comparators
    assign any_cmp = port0_return_sense | sense12_cmp | sense34_cmp;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // Path is the inverse of gate
    a_ground_inv: assert property (ground_path_on == !return_switch_gate)
        else $error("ground path");
    a_neg_force: assert property (neg_fault |-> force_overload == 5'h1f)
        else $error("negative fault force");
    a_cfg_echo: assert property (clk_en && cfg_wr |=>
        cfg_rdata == ($past(cfg_wdata) & 16'h007f)) else $error("config readback");
    a_sleep_back: assert property ($fell(sleep_switch_on) |->
        !sleep_switch_on [*5] ##[1:RHI] sleep_switch_on) else $error("sleep restart");
    a_trip_qual: assert property ($fell(return_switch_gate) |->
        $past(any_cmp, 4) && $past(any_cmp, 15)) else $error("unqualified trip");
    a_cmp_hold: assert property ($rose(any_cmp) && return_switch_gate |->
        return_switch_gate [*8]) else $error("trip too early");
    a_trip_fx: assert property ($fell(return_switch_gate) && !neg_fault |->
        !sleep_switch_on && force_overload != 5'h00) else $error("trip effects");
    a_no_force: assert property (return_switch_gate && !neg_fault |->
        force_overload == 5'h00) else $error("force without trip");
endmodule
////////////////////////////////////////
bind return_breaker_and_telemetry breaker_monitor #(.RESTART_CYC(RESTART_CYC)) mon_u (
    .ref_clk, .rst_n, .clk_en, .port0_return_sense, .sense12_cmp, .sense34_cmp, .neg_fault,
    .cfg_wr, .cfg_wdata, .cfg_rdata, .return_switch_gate, .ground_path_on,
    .sleep_switch_on, .force_overload);
`default_nettype wire

// [tb/return_path_model.sv]
`timescale 1ns/100ps
`default_nettype none
module return_path_model (
    input  wire logic       return_switch_gate, // Switch gate
    input  wire logic [2:0] overdraw,           // Excess load
    output logic      [2:0] cmp                 // Comparators
);
    // Excess current flows only while the return switch conducts
    assign cmp = overdraw & {3{return_switch_gate}};
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "breaker_cfg.svh"
module tb_top;
    localparam int FC = 40;
    localparam int PC = 20;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic [14:0] port_state = 15'h0000;
    logic        overcurrent = 1'b0;
    logic        neg_fault = 1'b0;
    logic        cfg_wr = 1'b0;
    logic        res_rd = 1'b0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [11:0] adc_code = 12'h000;
    logic [59:0] port_adc_code = 60'h0;
    logic [2:0]  overdraw = 3'h0;
    wire  [2:0]  cmp;
    logic [15:0] cfg_rdata, res_rdata;
    logic [79:0] port_res_rdata;
    logic [4:0]  force_overload;
    logic        return_switch_gate, ground_path_on, sleep_switch_on;
    logic [11:0] exp_q[$];
    logic        fresh_prev = 1'b0;
    int          error_cnt = 0;
    int          checked = 0;
    // Device with shortened counts and the return path model
    return_breaker_and_telemetry #(.FIRST_CYC(FC), .PERIOD_CYC(PC), .RESTART_CYC(8)) dut_u (
        .ref_clk, .rst_n, .clk_en, .port_state, .port0_return_sense(cmp[0]),
        .sense12_cmp(cmp[1]), .sense34_cmp(cmp[2]), .overcurrent, .neg_fault, .cfg_wr,
        .cfg_wdata, .res_rd, .adc_code, .port_adc_code, .cfg_rdata, .res_rdata,
        .port_res_rdata, .return_switch_gate, .ground_path_on, .sleep_switch_on,
        .force_overload);
    return_path_model model_u (.return_switch_gate, .overdraw, .cmp);
    // Clock at 125 MHz
    always #4 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic test_done;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Bounded wait on fresh flag (0), gate (1) or sleep switch (2)
    task automatic wait_on(input int w, input logic lvl, output int n);
        for (n = 1; n <= 60; n++)
        begin
            tick(1);
            if ((w == 0 ? res_rdata[12] : w == 1 ? return_switch_gate : sleep_switch_on) === lvl)
                return;
        end
        chk(1'b0, "wait timed out");
        test_done();
    endtask
    // Each rise of the fresh flag takes the oldest expected code
    always @(negedge ref_clk)
    begin
        if (res_rdata[12] === 1'b1 && !fresh_prev)
        begin
            checked++;
            if (exp_q.size() == 0 || res_rdata[11:0] !== exp_q.pop_front())
            begin
                error_cnt++;
                $display("CHECK FAILED %0t result code", $time);
            end
        end
        fresh_prev = res_rdata[12] === 1'b1;
    end
    ////////////////////////////////////////
    initial
    begin
        int          n;
        int          lo;
        int          hi;
        logic [11:0] code;
        logic [4:0]  sel;
        logic [15:0] exp_cur;
        real         temp_c;
        real         amps;
        void'($urandom(55));
        tick(5);
        rst_n = 1'b1;
        tick(1);
        chk({return_switch_gate, ground_path_on, sleep_switch_on} === 3'h3, "reset");
        port_state = {breaker_pkg::PS_SLEEP, breaker_pkg::PS_DISABLED, breaker_pkg::PS_IDLE,
                      breaker_pkg::PS_POWER_UP, breaker_pkg::PS_POWER_ON};
        tick(2);
        chk({return_switch_gate, ground_path_on} === 2'h2, "gate on idle");
        for (int i = 0; i < 3; i++)
        begin
            overdraw = 3'h1 << i;
            tick(12);
            overdraw = 3'h0;
            tick(1);
            chk(return_switch_gate === 1'b1, "early trip");
            overdraw = 3'h1 << i;
            wait_on(1, 1'b0, n);
            chk(n >= 16 && n <= 22, "trip time");
            chk({force_overload, sleep_switch_on} === 6'h2e, "trip effects");
            overdraw = 3'h0;
            if (i == 0)
            begin
                // Overcurrent inside the restart delay must not drop the trip
                overcurrent = 1'b1;
                tick(1);
                overcurrent = 1'b0;
                chk({return_switch_gate, force_overload} === 6'h17, "trip held");
            end
            wait_on(2, 1'b1, n);
            chk(n >= 6 && n <= 11, "restart");
            tick(3);
            chk({return_switch_gate, force_overload} === 6'h20, "recovered");
        end
        overcurrent = 1'b1;
        neg_fault = 1'b1;
        tick(1);
        overcurrent = 1'b0;
        chk({return_switch_gate, sleep_switch_on, force_overload} === 7'h5f, "fault");
        neg_fault = 1'b0;
        wait_on(2, 1'b1, n);
        chk(n >= 6 && n <= 11, "overcurrent restart");
        port_adc_code = {28'($urandom), 20'($urandom), 12'h9f4};
        tick(PC + 3);
        for (int g = 0; g < 5; g++)
        begin
            exp_cur = (g < 2) ? {4'h0, port_adc_code[12*g+:12]} : 16'h0000;
            chk(port_res_rdata[16*g+:16] === exp_cur, "port current");
        end
        // Host converts port 0 code with a 0.1 ohm sense
        amps = (real'(port_res_rdata[11:0]) - 2048.0) * 100.0e-6 / 0.1;
        chk(amps > 0.499 && amps < 0.501, "source current");
        for (int m = 0; m < 4; m++)
        begin
            sel = (m == 1) ? `SEL_TEMP : 5'($urandom);
            code = (m == 1) ? 12'hcb0 : 12'($urandom);
            adc_code = code;
            cfg_wdata = {9'($urandom), 2'(m), sel};
            cfg_wr = 1'b1;
            tick(1);
            if (m == 1)
            begin
                // Frozen clock enable ignores a standing write and holds the timer
                clk_en = 1'b0;
                cfg_wdata = ~cfg_wdata;
                tick(10);
                clk_en = 1'b1;
            end
            cfg_wr = 1'b0;
            chk(cfg_rdata === {9'h000, 2'(m), sel}, "config");
            for (int k = 0; k < m && k < 2 && m < 3; k++)
            begin
                exp_q.push_back(code);
                wait_on(0, 1'b1, n);
                lo = k ? PC - 3 : FC - 2;
                hi = k ? PC + 2 : FC + 3;
                chk(n >= lo && n <= hi, "result time");
                if (m == 1)
                begin
                    // Host reading of the temperature code
                    temp_c = (real'(res_rdata[11:0]) - 2048.0) / 4.0 - 273.15;
                    chk(temp_c > 26.84 && temp_c < 26.86, "temperature");
                end
                code = 12'($urandom);
                adc_code = code;
                res_rd = 1'b1;
                tick(1);
                res_rd = 1'b0;
                chk(res_rdata[12] === 1'b0, "flag clear");
            end
            if (m != 2)
            begin
                tick(FC + 4);
                chk(res_rdata[12] === 1'b0, "no result");
            end
        end
        test_done();
    end
endmodule
`default_nettype wire
